// >>> hw/core_timing.sv
// Instruction decode and machine-cycle timing for the fast core.
module core_timing (
    // Clock and reset.
    input  wire logic        clk_sys,
    input  wire logic        arst_n,
    // Program memory fetch side.
    input  wire logic [7:0]  fetch_data,
    output logic             fetch_req,
    // Datapath side.
    input  wire logic        alu_carry,
    input  wire logic        alu_aux,
    input  wire logic        alu_ovf,
    output logic [7:0]       opcode,
    output logic [2:0]       mc_total,
    output logic             is_branch,
    output logic             flag_we,
    output logic [2:0]       flags,
    output logic             instr_done
);

    //==========================================================================
    // Reset release
    //==========================================================================
    logic rst_meta_r;
    logic rst_n_r;

    // Releases the reset through two flip-flops.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta_r <= 1'b0;
            rst_n_r    <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n_r    <= rst_meta_r;
        end
    end

    //==========================================================================
    // Decode
    //==========================================================================
    core_timing_pkg::op_class_type cls_nxt;
    logic [2:0]                    mc_nxt;

    // Classifies an opcode and looks up its machine-cycle count.
    always_comb begin
        cls_nxt = core_timing_pkg::CLS_OTHER;
        mc_nxt  = core_timing_pkg::MC_ONE;
        if (fetch_data == core_timing_pkg::OP_NOP) begin
            cls_nxt = core_timing_pkg::CLS_NOP;
        end else if (fetch_data[4:0] == core_timing_pkg::OP_ABS_LOW) begin
            cls_nxt = core_timing_pkg::CLS_JMP;
            mc_nxt  = core_timing_pkg::MC_THREE;
        end else if (fetch_data[4:0] == core_timing_pkg::OP_ACALL_LOW) begin
            cls_nxt = core_timing_pkg::CLS_CALL;
            mc_nxt  = core_timing_pkg::MC_THREE;
        end else if (fetch_data == core_timing_pkg::OP_ADD_IMM
                  || fetch_data == core_timing_pkg::OP_ADD_DIR) begin
            cls_nxt = core_timing_pkg::CLS_ADD;
            mc_nxt  = core_timing_pkg::MC_TWO;
        end else if (fetch_data == core_timing_pkg::OP_ADDC_IMM
                  || fetch_data == core_timing_pkg::OP_ADDC_DIR) begin
            cls_nxt = core_timing_pkg::CLS_ADDC;
            mc_nxt  = core_timing_pkg::MC_TWO;
        end else if (fetch_data[7:4] == core_timing_pkg::OP_ADD_HI
                  && (fetch_data[3] || fetch_data[2:1] == 2'h3)) begin
            cls_nxt = core_timing_pkg::CLS_ADD;
        end else if (fetch_data[7:4] == core_timing_pkg::OP_ADDC_HI
                  && (fetch_data[3] || fetch_data[2:1] == 2'h3)) begin
            cls_nxt = core_timing_pkg::CLS_ADDC;
        end
    end

    //==========================================================================
    // Machine-cycle sequencer
    //==========================================================================
    // The opcode byte is fetched in the first machine cycle of every
    // instruction, and that cycle counts towards the instruction's total. A
    // one-byte form therefore ends in the same cycle that fetched it; only the
    // cycles after the opcode cycle are kept in the down-counter.
    core_timing_pkg::seq_state_type state_r;
    core_timing_pkg::op_class_type  cls_r;
    core_timing_pkg::op_class_type  cls_cur;
    logic [1:0]                     phase_r;
    logic [2:0]                     mc_left_r;
    logic                           mc_end;
    logic                           first_mc;
    logic                           one_mc_op;
    logic                           last_exec;
    logic                           finish;
    logic                           branch_cur;
    logic                           branch_nxt;
    logic                           fetch_slot;

    // Machine-cycle boundary and position within the instruction.
    assign mc_end     = (phase_r == core_timing_pkg::PHASE_LAST);
    assign first_mc   = (state_r == core_timing_pkg::ST_FETCH);
    assign one_mc_op  = (mc_nxt == core_timing_pkg::MC_ONE);
    assign last_exec  = (mc_left_r <= core_timing_pkg::MC_ONE);

    // The instruction ends at the close of its last machine cycle, which for a
    // one-cycle form is the opcode cycle itself.
    assign finish     = mc_end && (first_mc ? one_mc_op : last_exec);

    // The class in force is the incoming one during the opcode cycle, since a
    // one-cycle form finishes before its class could be registered.
    assign cls_cur    = first_mc ? cls_nxt : cls_r;

    // Jump and call classes of the held and of the incoming opcode.
    assign branch_cur = (cls_r == core_timing_pkg::CLS_JMP)
                     || (cls_r == core_timing_pkg::CLS_CALL);
    assign branch_nxt = (cls_nxt == core_timing_pkg::CLS_JMP)
                     || (cls_nxt == core_timing_pkg::CLS_CALL);

    // Every cycle fetches one byte, except the extra address cycle that
    // closes a jump or call; that cycle only forms the new program address.
    assign fetch_slot = first_mc || !(branch_cur && last_exec);

    // Counts four clocks per machine cycle.
    always_ff @(posedge clk_sys or negedge rst_n_r) begin
        if (!rst_n_r) begin
            phase_r <= core_timing_pkg::PHASE_RST;
        end else begin
            phase_r <= phase_r + 2'h1;
        end
    end

    // Leaves the opcode cycle only for forms that need further cycles and
    // returns to it at the close of the last one.
    always_ff @(posedge clk_sys or negedge rst_n_r) begin
        if (!rst_n_r) begin
            state_r <= core_timing_pkg::ST_FETCH;
        end else if (mc_end) begin
            case (state_r)
                core_timing_pkg::ST_FETCH: begin
                    if (!one_mc_op) begin
                        state_r <= core_timing_pkg::ST_EXEC;
                    end
                end
                core_timing_pkg::ST_EXEC: begin
                    if (last_exec) begin
                        state_r <= core_timing_pkg::ST_FETCH;
                    end
                end
                default: begin
                    state_r <= core_timing_pkg::ST_FETCH;
                end
            endcase
        end
    end

    // Takes the opcode, its class and its cycle count at the close of the opcode cycle and holds them until the next opcode cycle closes.
    always_ff @(posedge clk_sys or negedge rst_n_r) begin
        if (!rst_n_r) begin
            opcode   <= core_timing_pkg::OP_NOP;
            cls_r    <= core_timing_pkg::CLS_NOP;
            mc_total <= core_timing_pkg::MC_RST;
        end else if (mc_end && first_mc) begin
            opcode   <= fetch_data;
            cls_r    <= cls_nxt;
            mc_total <= mc_nxt;
        end
    end

    // Counts the cycles that follow the opcode cycle; a branch keeps one more
    // than its operand bytes for the address calculation.
    always_ff @(posedge clk_sys or negedge rst_n_r) begin
        if (!rst_n_r) begin
            mc_left_r <= core_timing_pkg::MC_RST;
        end else if (mc_end) begin
            if (first_mc) begin
                mc_left_r <= mc_nxt - core_timing_pkg::MC_ONE;
            end else if (!last_exec) begin
                mc_left_r <= mc_left_r - core_timing_pkg::MC_ONE;
            end
        end
    end

    //==========================================================================
    // Fetch and status outputs
    //==========================================================================
    // Requests one byte during the fourth clock of each fetching cycle, so the
    // memory steps on the same edge at which the byte is taken.
    always_ff @(posedge clk_sys or negedge rst_n_r) begin
        if (!rst_n_r) begin
            fetch_req <= 1'b0;
        end else begin
            fetch_req <= (phase_r == core_timing_pkg::PHASE_FETCH) && fetch_slot;
        end
    end

    // Pulses for one clock after the last machine cycle of an instruction.
    always_ff @(posedge clk_sys or negedge rst_n_r) begin
        if (!rst_n_r) begin
            instr_done <= 1'b0;
        end else begin
            instr_done <= finish;
        end
    end

    // Stays high from the close of the opcode cycle to the end of a branch.
    always_ff @(posedge clk_sys or negedge rst_n_r) begin
        if (!rst_n_r) begin
            is_branch <= 1'b0;
        end else if (finish) begin
            is_branch <= 1'b0;
        end else if (mc_end && first_mc) begin
            is_branch <= branch_nxt;
        end
    end

    //==========================================================================
    // Flags
    //==========================================================================
    logic       add_cur;
    logic       flag_upd;
    logic [2:0] alu_flags;
    wire  [2:0] flags_nxt;

    // The flags change only at the close of an add-class instruction.
    assign add_cur  = (cls_cur == core_timing_pkg::CLS_ADD)
                   || (cls_cur == core_timing_pkg::CLS_ADDC);
    assign flag_upd = finish && add_cur;

    // Gathers the datapath result flags into the flag layout.
    always_comb begin
        alu_flags                           = core_timing_pkg::FLAGS_RST;
        alu_flags[core_timing_pkg::FLAG_CY] = alu_carry;
        alu_flags[core_timing_pkg::FLAG_AC] = alu_aux;
        alu_flags[core_timing_pkg::FLAG_OV] = alu_ovf;
    end

    // Each flag bit takes its result on an update and otherwise keeps its
    // value, so every other class leaves carry, overflow and aux carry alone.
    for (genvar i = 0; i < 3; i++) begin : g_flag
        assign flags_nxt[i] = flag_upd ? alu_flags[i] : flags[i];
    end

    // Registers the flag vector with the same meaning as the conventional core.
    always_ff @(posedge clk_sys or negedge rst_n_r) begin
        if (!rst_n_r) begin
            flags <= core_timing_pkg::FLAGS_RST;
        end else begin
            flags <= flags_nxt;
        end
    end

    // Pulses for one clock when the flag vector has been written.
    always_ff @(posedge clk_sys or negedge rst_n_r) begin
        if (!rst_n_r) begin
            flag_we <= 1'b0;
        end else begin
            flag_we <= flag_upd;
        end
    end

endmodule

// >>> hw/core_timing_pkg.sv
// Constants and types shared by the instruction timing block.
//==============================================================================
// What this block does
// - Flag effects match conventional family behaviour.
// - Machine cycle is exactly four clocks.
// - At most one byte fetch per cycle.
// - Cycle count equals byte count, except jumps and calls.
// - Jumps and calls add one cycle.
// - Add-class sets C/OV/AC; all other classes keep C.
// - Carry-only instructions leave OV, AC alone.
// - Direct/immediate add forms take two cycles.
// - Absolute call/jump: two bytes, three cycles.
//==============================================================================
package core_timing_pkg;

    // Clock periods in one machine cycle.
    localparam int unsigned CLKS_PER_MC   = 4;
    localparam int unsigned PHASE_W       = 2;
    localparam logic [1:0]  PHASE_LAST    = 2'h3;
    localparam logic [1:0]  PHASE_RST     = 2'h0;
    // Phase at whose edge the fetch request for the fourth clock is raised.
    localparam logic [1:0]  PHASE_FETCH   = 2'h2;
    // Machine-cycle counter width and reset.
    localparam logic [2:0]  MC_ONE        = 3'h1;
    localparam logic [2:0]  MC_TWO        = 3'h2;
    localparam logic [2:0]  MC_THREE      = 3'h3;
    localparam logic [2:0]  MC_RST        = 3'h0;
    // Opcode groups.
    localparam logic [7:0]  OP_NOP        = 8'h00;
    localparam logic [7:0]  OP_ADD_IMM    = 8'h24;
    localparam logic [7:0]  OP_ADD_DIR    = 8'h25;
    localparam logic [7:0]  OP_ADDC_IMM   = 8'h34;
    localparam logic [7:0]  OP_ADDC_DIR   = 8'h35;
    localparam logic [4:0]  OP_ABS_LOW    = 5'h01;
    localparam logic [4:0]  OP_ACALL_LOW  = 5'h11;
    localparam logic [3:0]  OP_ADD_HI     = 4'h2;
    localparam logic [3:0]  OP_ADDC_HI    = 4'h3;
    // Flag bit positions in the flag vector (C, AC, OV).
    localparam int unsigned FLAG_CY       = 2;
    localparam int unsigned FLAG_AC       = 1;
    localparam int unsigned FLAG_OV       = 0;
    localparam logic [2:0]  FLAGS_RST     = 3'h0;

    // Decode class of an opcode.
    typedef enum logic [2:0] {
        CLS_NOP, CLS_ADD, CLS_ADDC, CLS_JMP, CLS_CALL, CLS_OTHER
    } op_class_type;

    // Sequencer states.
    typedef enum logic [1:0] {
        ST_FETCH, ST_EXEC
    } seq_state_type;

endpackage

// >>> tb/core_timing_asserts.sv
// Port checker for the instruction timing block.
module core_timing_asserts (
    // Clock and reset.
    input wire logic       clk_sys,
    input wire logic       arst_n,
    // Watched ports.
    input wire logic       fetch_req,
    input wire logic       alu_carry,
    input wire logic       alu_aux,
    input wire logic       alu_ovf,
    input wire logic [7:0] opcode,
    input wire logic [2:0] mc_total,
    input wire logic       is_branch,
    input wire logic       flag_we,
    input wire logic [2:0] flags,
    input wire logic       instr_done
);
    timeunit 1ns;
    timeprecision 1ps;
    // ========
    // Checks.
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    fetch_once_a: assert property (fetch_req |=> !fetch_req [*3])
        else $error("two fetches in one machine cycle");
    done_gap_a: assert property (instr_done |=> !instr_done [*3])
        else $error("instructions closer than four clocks");
    flag_once_a: assert property (flag_we |=> !flag_we [*3])
        else $error("flags written twice in one instruction");
    flags_alu_a: assert property (flag_we |-> flags == $past({alu_carry, alu_aux, alu_ovf}))
        else $error("flags differ from datapath result");
    flags_hold_a: assert property (!flag_we |-> $stable(flags))
        else $error("flags moved without a write");
    flag_class_a: assert property (flag_we |-> opcode[7:5] == 3'h1 && opcode[3:2] != 2'h0)
        else $error("flags written by a non-add instruction");
    mc_range_a: assert property (instr_done |-> mc_total inside {3'h1, 3'h2, 3'h3})
        else $error("cycle count out of range");
    branch_mc_a: assert property (is_branch |-> mc_total == 3'h3)
        else $error("branch without three cycles");
    nop_mc_a: assert property (instr_done && opcode == 8'h00 |-> mc_total == 3'h1)
        else $error("no-operation not one cycle");
    cover property (is_branch);
    cover property (flag_we);
    cover property (instr_done && mc_total == 3'h2);
endmodule
bind core_timing core_timing_asserts chk (.clk_sys(clk_sys), .arst_n(arst_n),
    .fetch_req(fetch_req), .alu_carry(alu_carry), .alu_aux(alu_aux), .alu_ovf(alu_ovf),
    .opcode(opcode), .mc_total(mc_total), .is_branch(is_branch), .flag_we(flag_we),
    .flags(flags), .instr_done(instr_done));

// >>> tb/core_timing_tb.sv
// Self-checking bench for the instruction timing block.
module core_timing_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk_sys = 1'b0;
    logic       arst_n = 1'b0;
    logic       fetch_req, flag_we, instr_done, is_branch;
    logic [7:0] fetch_data, opcode;
    logic [2:0] mc_total, flags, alu_r = 3'h5, flags_exp = 3'h0;
    int         fails = 0, n_tests = 0, wr = 0, t_last = 0, cyc = 0;
    bit         loading = 1'b1;
    always #20 clk_sys = ~clk_sys;
    always @(posedge clk_sys) cyc <= cyc + 1;
    core_timing dut (.clk_sys(clk_sys), .arst_n(arst_n), .fetch_data(fetch_data),
        .fetch_req(fetch_req), .alu_carry(alu_r[2]), .alu_aux(alu_r[1]), .alu_ovf(alu_r[0]),
        .opcode(opcode), .mc_total(mc_total), .is_branch(is_branch), .flag_we(flag_we),
        .flags(flags), .instr_done(instr_done));
    prog_mem mem (.clk_sys(clk_sys), .arst_n(arst_n), .fetch_req(fetch_req),
        .fetch_data(fetch_data));
    // ========
    // Compare and step tasks.
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Loads one instruction, or waits for its end and judges it.
    task automatic step(input logic [7:0] op);
        int mc, n;
        bit seen;
        mc = (op[4:0] == 5'h01 || op[4:0] == 5'h11) ? 3 :
             (op inside {8'h24, 8'h25, 8'h34, 8'h35}) ? 2 : 1;
        if (loading) begin
            mem.rom[wr] = op;
            mem.rom[wr + 1] = 8'hA5;
            wr += (mc > 1) ? 2 : 1;
        end else begin
            n = 0;
            seen = 1'b0;
            do begin
                @(posedge clk_sys);
                #1;
                n++;
                seen = seen || is_branch === 1'b1;
            end while (instr_done !== 1'b1 && n < 100);
            chk({7'h00, instr_done}, 8'h01);
            chk(opcode, op);
            chk({5'h00, mc_total}, 8'(mc));
            if (t_last > 0) chk(8'(cyc - t_last), 8'(4 * mc));
            chk({7'h00, seen}, (mc == 3) ? 8'h01 : 8'h00);
            t_last = cyc;
            if (op[7:5] == 3'h1 && op[3:2] != 2'h0) flags_exp = alu_r;
            chk({5'h00, flags}, {5'h00, flags_exp});
            @(posedge clk_sys);
            alu_r <= alu_r + 3'h3;
        end
    endtask
    // Single-cycle forms back to back, closed by one that leaves the flags.
    task automatic t_one_cycle();
        logic [7:0] ops [10] = '{8'h00, 8'h28, 8'h2F, 8'h26, 8'h27,
                                 8'h38, 8'h3F, 8'h36, 8'h37, 8'h14};
        foreach (ops[i]) step(ops[i]);
    endtask
    // Two-byte direct and immediate forms.
    task automatic t_two_cycle();
        logic [7:0] ops [4] = '{8'h25, 8'h24, 8'h35, 8'h34};
        foreach (ops[i]) step(ops[i]);
    endtask
    // Every absolute jump and call opcode.
    task automatic t_branch();
        for (int k = 0; k < 8; k++) begin
            step({k[2:0], 5'h01});
            step({k[2:0], 5'h11});
        end
    endtask
    task automatic print_verdict();
        $display("fails %0d n_tests %0d", fails, n_tests);
        if (fails == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Main sequence: load the program, release reset, then judge it.
    initial begin
        foreach (mem.rom[i]) mem.rom[i] = 8'h00;
        t_one_cycle();
        t_two_cycle();
        t_branch();
        loading = 1'b0;
        repeat (6) @(posedge clk_sys);
        arst_n <= 1'b1;
        t_one_cycle();
        t_two_cycle();
        t_branch();
        print_verdict();
    end
    // Watchdog cuts a hang short.
    initial begin
        repeat (5000) @(posedge clk_sys);
        fails++;
        $display("[ERR] %0t watchdog expired", $time);
        print_verdict();
    end
endmodule

// >>> tb/prog_mem.sv
// Program memory model that hands instruction bytes to the core.
module prog_mem (
    // Clock and reset.
    input  wire logic       clk_sys,
    input  wire logic       arst_n,
    // Fetch side.
    input  wire logic       fetch_req,
    output logic      [7:0] fetch_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] rom [256];
    logic [7:0] ptr_r;
    // The byte at the pointer stays valid; each fetch steps to the next one.
    assign fetch_data = rom[ptr_r];
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) ptr_r <= 8'h00;
        else if (fetch_req) ptr_r <= ptr_r + 8'h01;
    end
endmodule
